// >>> hw/cbm_pkg.sv
/*
 * Constants, types and helper functions for the configuration bank manager.
 * Assumes one 100 MHz clock and an active-low asynchronous reset in the user module.
 */
// Functional notes
// [R01] Four banks 0..3: banks 0-2 non-volatile, bank 3 fixed read-only defaults.
// [R02] User bank restore/update and install restore by supervisor+; install update factory/service.
// [R03] At start-up the user bank is loaded into the working RAM copy.
// [R04] Calibration completion writes calibration data into the user bank only.
// [R05] Defaults restore overwrites all factory items in RAM, serial and identity included.
// [R06] Default calibration values force an under-range calibration error report.
// [R07] A restore reloads every configuration item, not just those of the bank.
// [R08] Each restored item comes from the selected bank or the next higher holder.
// [R09] Temperature compensation lives only in factory bank, reached by fall-through.
// [R10] Interface writes change RAM only; banks change by update or calibration.
// [R11] An update stores only the items the selected bank is defined to hold.
// [R12] Factory bank update only by factory, or service with diagnostic rights.
// [R13] Defaults bank never updated; restored only by factory or diagnostic service.
// [R14] Persistence needs an explicit bank update, which commits RAM to storage.
// [R15] Monitored values sit at contiguous indices for one multiple read.
// [R16] Filtered, unfiltered concentration and slope are separate readable values.
// [R17] Operating mode value shows operational or non-operational mode.
// [R18] Overall operational state is one enumerated value.
// [R19] Each contributing condition is a separate flag bit.
// [R20] Status shows busy, then success or failure; idle command returns ready.
// [R21] Diagnostic rights granted only after the correct validation code.
// [R22] Refused requests change no bank nor RAM and report failure.
package cbm_pkg;

    // ****************************************
    // sizes and item map
    // ****************************************
    localparam int DATA_W = 16;
    localparam int ITEMS = 8;
    localparam int NV_BANKS = 3;
    localparam int MON_WORDS = 7;
    localparam logic [2:0] ITEM_SERIAL = 3'h0;
    localparam logic [2:0] ITEM_IDENT = 3'h1;
    localparam logic [2:0] ITEM_TEMPCOMP = 3'h2;
    localparam logic [2:0] ITEM_CAL_ZERO = 3'h3;
    localparam logic [2:0] ITEM_CAL_GAIN = 3'h4;
    localparam logic [2:0] ITEM_LAST = 3'h7;
    localparam logic [1:0] BANK_USER = 2'h0;
    localparam logic [1:0] BANK_INSTALL = 2'h1;
    localparam logic [1:0] BANK_FACTORY = 2'h2;
    localparam logic [1:0] BANK_DEFAULTS = 2'h3;

    // items held per bank, bit n = item n
    localparam logic [7:0] HOLD_USER = 8'hB8;
    localparam logic [7:0] HOLD_INSTALL = 8'hF8;
    localparam logic [7:0] HOLD_FACTORY = 8'hFF;
    localparam logic [7:0] HOLD_DEFAULTS = 8'hFF;

    // diagnostic validation code, value arbitrary
    localparam logic [15:0] DIAG_KEY = 16'h5A3C;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {OP_IDLE, OP_RESTORE, OP_UPDATE} cbm_op_t;
    typedef enum logic [1:0] {CL_OPERATOR, CL_SUPERVISOR, CL_FACTORY, CL_SERVICE} cbm_class_t;
    typedef enum logic [1:0] {ST_READY, ST_BUSY, ST_SUCCESS, ST_FAIL} cbm_status_t;
    typedef enum logic {S_IDLE, S_RUN} cbm_seq_t;

    // ****************************************
    // functions
    // ****************************************
    function automatic logic [7:0] bank_hold(input logic [1:0] bank);
        case (bank)
            BANK_USER: bank_hold = HOLD_USER;
            BANK_INSTALL: bank_hold = HOLD_INSTALL;
            BANK_FACTORY: bank_hold = HOLD_FACTORY;
            default: bank_hold = HOLD_DEFAULTS;
        endcase
    endfunction : bank_hold

    // first bank at or above sel that holds the item
    function automatic logic [1:0] src_bank(input logic [1:0] sel, input logic [2:0] item);
        logic [1:0] b;
        b = BANK_DEFAULTS;
        for (int i = 2; i >= 0; i--) begin
            if (2'(i) >= sel && ((bank_hold(2'(i)) >> item) & 8'h01) != 8'h00) begin
                b = 2'(i);
            end
        end
        src_bank = b;
    endfunction : src_bank

    // fixed defaults; zero gain forces under-range
    function automatic logic [15:0] default_item(input logic [2:0] item);
        case (item)
            ITEM_SERIAL: default_item = 16'h0000;
            ITEM_IDENT: default_item = 16'h0000;
            ITEM_TEMPCOMP: default_item = 16'h0100;
            ITEM_CAL_ZERO: default_item = 16'h0000;
            ITEM_CAL_GAIN: default_item = 16'h0000;
            default: default_item = 16'h0000;
        endcase
    endfunction : default_item

endpackage : cbm_pkg

// >>> hw/cbm_config_bank_manager.sv
/*
 * Configuration bank manager: working RAM copy, three non-volatile banks,
 * one read-only defaults bank, restore/update sequencer, access checks and
 * monitoring values.
 * Assumes inputs synchronous to core_clk; the command issuer holds the
 * user class and supplies one-cycle request strobes.
 */
`timescale 1ns/1ps
`default_nettype none
module cbm_config_bank_manager (
    input wire logic core_clk,
    input wire logic rstn,
    input wire cbm_pkg::cbm_class_t user_class,
    input wire logic diag_wr,
    input wire logic [15:0] diag_code,
    output logic diag_rights,
    input wire logic cmd_valid,
    input wire cbm_pkg::cbm_op_t cmd_op,
    input wire logic [1:0] cmd_bank,
    output logic cmd_ready,
    output cbm_pkg::cbm_status_t bank_status,
    input wire logic cfg_wr_en,
    input wire logic [2:0] cfg_wr_idx,
    input wire logic [15:0] cfg_wr_data,
    input wire logic [2:0] cfg_rd_idx,
    output logic [15:0] cfg_rd_data,
    input wire logic cal_done,
    input wire logic [15:0] cal_zero_data,
    input wire logic [15:0] cal_gain_data,
    output logic cal_under_range,
    input wire logic [15:0] gas_filtered_in,
    input wire logic [15:0] gas_raw_in,
    input wire logic [15:0] concentration_slope_in,
    input wire logic [15:0] mode_in,
    input wire logic [15:0] state_in,
    input wire logic [15:0] conditions_in,
    output logic [15:0] gas_filtered,
    output logic [15:0] gas_raw,
    output logic [15:0] concentration_slope,
    output logic [15:0] op_mode,
    output logic [15:0] op_state,
    output logic [15:0] conditions,
    input wire logic [2:0] mon_rd_idx,
    output logic [15:0] mon_rd_data
);
    import cbm_pkg::*;

    // ****************************************
    // storage
    // ****************************************
    logic [15:0] ram [0:ITEMS-1];
    logic [15:0] nv [0:NV_BANKS*ITEMS-1];
    cbm_seq_t seq;
    cbm_op_t op_q;
    logic [1:0] bank_q;
    logic [2:0] item;
    logic boot_pending;
    logic boot_run;
    logic step;
    logic allowed;
    logic [1:0] src;
    logic [15:0] src_word;
    logic [4:0] upd_addr;

    // ****************************************
    // access rights
    // ****************************************
    function automatic logic rights_ok(input cbm_op_t op, input logic [1:0] bank,
                                       input cbm_class_t cls, input logic diag);
        logic fact;
        logic serv_diag;
        logic sup_up;
        fact = (cls == CL_FACTORY);
        serv_diag = (cls == CL_SERVICE) && diag;
        sup_up = (cls != CL_OPERATOR);
        rights_ok = 1'b0;
        case (bank)
            BANK_USER: rights_ok = sup_up; // see [R02]
            BANK_INSTALL: rights_ok = (op == OP_RESTORE) ? sup_up : (fact || cls == CL_SERVICE); // see [R02]
            BANK_FACTORY: rights_ok = (op == OP_RESTORE) ? (fact || cls == CL_SERVICE) : (fact || serv_diag); // see [R12]
            default: rights_ok = (op == OP_RESTORE) && (fact || serv_diag); // see [R13]
        endcase
    endfunction : rights_ok

    assign allowed = (cmd_op != OP_IDLE) && rights_ok(cmd_op, cmd_bank, user_class, diag_rights);
    assign cmd_ready = (seq == S_IDLE) && !boot_pending;
    // calibration write takes the bank port, sequence waits one cycle
    assign step = (seq == S_RUN) && !cal_done;
    assign src = src_bank(bank_q, item); // see [R08]
    assign src_word = (src == BANK_DEFAULTS) ? default_item(item) : nv[{src, item}]; // see [R01]
    assign upd_addr = {bank_q, item};

    // ****************************************
    // diagnostic rights
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            diag_rights <= 1'b0;
        end else if (diag_wr) begin
            diag_rights <= (diag_code == DIAG_KEY) && (user_class != CL_OPERATOR); // see [R21]
        end
    end

    // ****************************************
    // sequencer and status
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            seq <= S_IDLE;
            op_q <= OP_IDLE;
            bank_q <= BANK_USER;
            item <= 3'h0;
            boot_pending <= 1'b1;
            boot_run <= 1'b0;
            bank_status <= ST_READY;
        end else begin
            case (seq)
                S_IDLE: begin
                    if (boot_pending) begin
                        boot_pending <= 1'b0; // see [R03]
                        boot_run <= 1'b1;
                        seq <= S_RUN;
                        op_q <= OP_RESTORE;
                        bank_q <= BANK_USER;
                        item <= 3'h0;
                        bank_status <= ST_BUSY;
                    end else if (cmd_valid) begin
                        if (cmd_op == OP_IDLE) begin
                            bank_status <= ST_READY; // see [R20]
                        end else if (allowed) begin
                            seq <= S_RUN; // see [R14]
                            op_q <= cmd_op;
                            bank_q <= cmd_bank;
                            item <= 3'h0;
                            bank_status <= ST_BUSY; // see [R20]
                        end else begin
                            bank_status <= ST_FAIL; // see [R22]
                        end
                    end
                end
                S_RUN: begin
                    if (step) begin
                        item <= item + 3'h1;
                        if (item == ITEM_LAST) begin
                            seq <= S_IDLE; // see [R07]
                            boot_run <= 1'b0;
                            bank_status <= boot_run ? ST_READY : ST_SUCCESS; // see [R20]
                        end
                    end
                end
                default: begin
                    seq <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // working RAM copy
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (cal_done) begin
            ram[ITEM_CAL_ZERO] <= cal_zero_data;
            ram[ITEM_CAL_GAIN] <= cal_gain_data;
        end else if (step && op_q == OP_RESTORE) begin
            ram[item] <= src_word; // see [R05] see [R07] see [R09]
        end else if (cfg_wr_en && seq == S_IDLE) begin
            ram[cfg_wr_idx] <= cfg_wr_data; // see [R10]
        end
    end

    // ****************************************
    // non-volatile banks
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (cal_done) begin
            nv[{BANK_USER, ITEM_CAL_ZERO}] <= cal_zero_data; // see [R04]
            nv[{BANK_USER, ITEM_CAL_GAIN}] <= cal_gain_data; // see [R04]
        end else if (step && op_q == OP_UPDATE && bank_q != BANK_DEFAULTS
                     && ((bank_hold(bank_q) >> item) & 8'h01) != 8'h00) begin
            nv[upd_addr] <= ram[item]; // see [R11] see [R14]
        end
    end

    // ****************************************
    // readback and calibration check
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cfg_rd_data <= RESET_WORD;
            cal_under_range <= 1'b0;
        end else begin
            cfg_rd_data <= ram[cfg_rd_idx];
            cal_under_range <= (seq == S_IDLE) && !boot_pending && (ram[ITEM_CAL_GAIN] == RESET_WORD); // see [R06]
        end
    end

    // ****************************************
    // monitoring values
    // ****************************************
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            gas_filtered <= RESET_WORD;
            gas_raw <= RESET_WORD;
            concentration_slope <= RESET_WORD;
            op_mode <= RESET_WORD;
            op_state <= RESET_WORD;
            conditions <= RESET_WORD;
        end else begin
            gas_filtered <= gas_filtered_in; // see [R16]
            gas_raw <= gas_raw_in; // see [R16]
            concentration_slope <= concentration_slope_in; // see [R16]
            op_mode <= mode_in; // see [R17]
            op_state <= state_in; // see [R18]
            conditions <= conditions_in; // see [R19]
        end
    end

    // contiguous window for one multiple read
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mon_rd_data <= RESET_WORD;
        end else begin
            case (mon_rd_idx) // see [R15]
                3'h0: mon_rd_data <= gas_filtered;
                3'h1: mon_rd_data <= gas_raw;
                3'h2: mon_rd_data <= concentration_slope;
                3'h3: mon_rd_data <= op_mode;
                3'h4: mon_rd_data <= op_state;
                3'h5: mon_rd_data <= conditions;
                3'h6: mon_rd_data <= {14'h0000, bank_status};
                default: mon_rd_data <= RESET_WORD;
            endcase
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    a_rom_no_update: assert property ( // see [R13]
        cmd_ready && cmd_valid && cmd_op == OP_UPDATE && cmd_bank == BANK_DEFAULTS |=> bank_status == ST_FAIL)
        else $error("defaults bank update accepted");
    a_factory_upd_rights: assert property ( // see [R12]
        cmd_ready && cmd_valid && cmd_op == OP_UPDATE && cmd_bank == BANK_FACTORY
        && user_class == CL_SERVICE && !diag_rights |=> bank_status == ST_FAIL && seq == S_IDLE)
        else $error("factory update without rights");
    a_install_upd_super: assert property ( // see [R02]
        cmd_ready && cmd_valid && cmd_op == OP_UPDATE && cmd_bank == BANK_INSTALL
        && user_class == CL_SUPERVISOR |=> bank_status == ST_FAIL)
        else $error("supervisor updated install bank");
    a_user_restore_go: assert property ( // see [R02]
        cmd_ready && cmd_valid && cmd_op == OP_RESTORE && cmd_bank == BANK_USER
        && user_class != CL_OPERATOR |=> seq == S_RUN && bank_status == ST_BUSY)
        else $error("user restore not started");
    a_idle_to_ready: assert property ( // see [R20]
        cmd_ready && cmd_valid && cmd_op == OP_IDLE |=> bank_status == ST_READY)
        else $error("idle command did not clear status");
    a_run_ends_done: assert property ( // see [R07]
        step && item == ITEM_LAST && !boot_run |=> seq == S_IDLE && bank_status == ST_SUCCESS)
        else $error("sequence did not finish after last item");
    a_refused_stays: assert property ( // see [R22]
        cmd_ready && cmd_valid && cmd_op != OP_IDLE && !allowed |=> seq == S_IDLE && bank_status == ST_FAIL)
        else $error("refused request started a sequence");
    a_boot_restore: assert property ( // see [R03]
        $fell(boot_pending) |-> seq == S_RUN && bank_q == BANK_USER && op_q == OP_RESTORE)
        else $error("start-up restore of user bank missing");
    a_tempcomp_source: assert property ( // see [R09]
        seq == S_RUN && item == ITEM_TEMPCOMP && bank_q != BANK_DEFAULTS |-> src == BANK_FACTORY)
        else $error("temperature compensation not from factory bank");
    a_cal_user_bank: assert property ( // see [R04]
        cal_done |=> nv[{BANK_USER, ITEM_CAL_GAIN}] == $past(cal_gain_data) && ram[ITEM_CAL_GAIN] == $past(cal_gain_data))
        else $error("calibration not stored in user bank");
    a_diag_bad_code: assert property ( // see [R21]
        diag_wr && diag_code != DIAG_KEY |=> !diag_rights)
        else $error("diagnostic rights granted on bad code");
    a_restore_length: assert property ( // see [R07]
        $rose(seq == S_RUN) ##0 (!cal_done) [*8] |-> seq == S_RUN ##1 seq == S_IDLE)
        else $error("restore did not cover all items");

    c_boot_done: cover property ($fell(boot_run));
    c_update_ok: cover property (op_q == OP_UPDATE && bank_status == ST_SUCCESS);
    c_defaults_restore: cover property (seq == S_RUN && bank_q == BANK_DEFAULTS && op_q == OP_RESTORE);
    c_refused: cover property (bank_status == ST_FAIL);

endmodule : cbm_config_bank_manager
`default_nettype wire

// >>> tb/cbm_master_model.sv
/*
 * Bus master model for the bank manager: bank requests, diagnostic code,
 * working-copy writes and reads.
 * Assumes the bench clock; drives on falling edges, design samples on rising.
 */
`timescale 1ns/1ps
`default_nettype none
module cbm_master_model (
    input wire logic core_clk,
    input wire logic cmd_ready,
    input wire cbm_pkg::cbm_status_t bank_status,
    input wire logic [15:0] cfg_rd_data,
    output var cbm_pkg::cbm_class_t user_class,
    output var logic diag_wr,
    output var logic [15:0] diag_code,
    output var logic cmd_valid,
    output var cbm_pkg::cbm_op_t cmd_op,
    output var logic [1:0] cmd_bank,
    output var logic cfg_wr_en,
    output var logic [2:0] cfg_wr_idx,
    output var logic [15:0] cfg_wr_data,
    output var logic [2:0] cfg_rd_idx
);
    import cbm_pkg::*;
    int hangs = 0;
    initial begin
        user_class = CL_OPERATOR;
        {diag_wr, cmd_valid, cfg_wr_en} = 3'h0;
        {diag_code, cfg_wr_data} = 32'h0000_0000;
        {cmd_bank, cfg_wr_idx, cfg_rd_idx} = 8'h00;
        cmd_op = OP_IDLE;
    end

    // ****************************************
    // requests
    // ****************************************
    // one request, then poll status until busy ends
    task automatic request(input cbm_op_t op, input logic [1:0] bank, input cbm_class_t cls,
                           output cbm_status_t st, output int busy);
        int n;
        n = 0;
        busy = 0;
        @(negedge core_clk);
        while (cmd_ready !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 50) hangs++;
        user_class = cls;
        cmd_op = op;
        cmd_bank = bank;
        cmd_valid = 1'b1;
        @(negedge core_clk);
        cmd_valid = 1'b0;
        cmd_bank = ~bank;
        while (bank_status === ST_BUSY && busy < 40) begin
            busy++;
            @(negedge core_clk);
        end
        if (busy == 40) hangs++;
        st = bank_status;
    endtask : request

    task automatic diag(input cbm_class_t cls, input logic [15:0] code);
        @(negedge core_clk);
        user_class = cls;
        diag_wr = 1'b1;
        diag_code = code;
        @(negedge core_clk);
        diag_wr = 1'b0;
        diag_code = ~code;
    endtask : diag

    task automatic cfg_write(input logic [2:0] idx, input logic [15:0] d);
        @(negedge core_clk);
        cfg_wr_en = 1'b1;
        cfg_wr_idx = idx;
        cfg_wr_data = d;
        @(negedge core_clk);
        cfg_wr_en = 1'b0;
        cfg_wr_data = ~d;
    endtask : cfg_write

    task automatic cfg_read(input logic [2:0] idx, output logic [15:0] d);
        @(negedge core_clk);
        cfg_rd_idx = idx;
        @(negedge core_clk);
        d = cfg_rd_data;
    endtask : cfg_read
endmodule : cbm_master_model
`default_nettype wire

// >>> tb/cbm_config_bank_manager_test.sv
/*
 * Self-checking bench for the configuration bank manager.
 * Assumes cbm_pkg and the master model in cbm_master_model.sv.
 */
`timescale 1ns/1ps
`default_nettype none
module cbm_config_bank_manager_test;
    import cbm_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic cal_done = 1'b0;
    logic [15:0] cal_zero_data = 16'h0000;
    logic [15:0] cal_gain_data = 16'h0000;
    logic [15:0] mon_in [6] = '{default: 16'h0000};
    logic [2:0] mon_rd_idx = 3'h0;
    wire cbm_class_t user_class;
    wire cbm_op_t cmd_op;
    wire cbm_status_t bank_status;
    wire diag_wr, diag_rights, cmd_valid, cmd_ready, cfg_wr_en, cal_under_range;
    wire [1:0] cmd_bank;
    wire [2:0] cfg_wr_idx, cfg_rd_idx;
    wire [15:0] diag_code, cfg_wr_data, cfg_rd_data, mon_rd_data;
    wire [15:0] mon_out [6];
    cbm_status_t st;
    int busy;
    int n_fail = 0;
    int total_checks = 0;
    always #5 core_clk = ~core_clk;

    cbm_config_bank_manager i_dut (.core_clk(core_clk), .rstn(rstn), .user_class(user_class),
        .diag_wr(diag_wr), .diag_code(diag_code), .diag_rights(diag_rights), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cmd_ready(cmd_ready), .bank_status(bank_status),
        .cfg_wr_en(cfg_wr_en), .cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data),
        .cfg_rd_idx(cfg_rd_idx), .cfg_rd_data(cfg_rd_data), .cal_done(cal_done),
        .cal_zero_data(cal_zero_data), .cal_gain_data(cal_gain_data), .cal_under_range(cal_under_range),
        .gas_filtered_in(mon_in[0]), .gas_raw_in(mon_in[1]), .concentration_slope_in(mon_in[2]),
        .mode_in(mon_in[3]), .state_in(mon_in[4]), .conditions_in(mon_in[5]),
        .gas_filtered(mon_out[0]), .gas_raw(mon_out[1]), .concentration_slope(mon_out[2]),
        .op_mode(mon_out[3]), .op_state(mon_out[4]), .conditions(mon_out[5]),
        .mon_rd_idx(mon_rd_idx), .mon_rd_data(mon_rd_data));
    cbm_master_model i_master (.core_clk(core_clk), .cmd_ready(cmd_ready), .bank_status(bank_status),
        .cfg_rd_data(cfg_rd_data), .user_class(user_class), .diag_wr(diag_wr), .diag_code(diag_code),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_bank(cmd_bank), .cfg_wr_en(cfg_wr_en),
        .cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data), .cfg_rd_idx(cfg_rd_idx));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk16

    task automatic chk_st(input cbm_status_t got, input cbm_status_t exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t %s status %0d exp %0d", $time, what, got, exp);
        end
    endtask : chk_st

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    task automatic end_test(input string name);
        if (i_master.hangs != 0) begin
            n_fail++;
            $display("FAIL %0t wait bound used up in %s", $time, name);
            give_verdict();
        end
        $display("test %s done", name);
    endtask : end_test

    task automatic req_chk(input cbm_op_t op, input int b, input cbm_class_t c, input cbm_status_t e);
        i_master.request(op, 2'(b), c, st, busy);
        chk_st(st, e, "request outcome");
    endtask : req_chk

    task automatic rd_chk(input int idx, input logic [15:0] exp, input string what);
        logic [15:0] d;
        i_master.cfg_read(3'(idx), d);
        chk16(d, exp, what);
    endtask : rd_chk

    // first bank at or above sel holding the item
    function automatic logic [15:0] exp_item(input int sel, input int i);
        logic [7:0] h [3];
        h = '{HOLD_USER, HOLD_INSTALL, HOLD_FACTORY};
        for (int b = sel; b < 3; b++) begin
            if (h[b][i]) begin
                return {4'(b + 1), 12'(i)};
            end
        end
        return 16'hDEAD;
    endfunction : exp_item

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_startup;
        int n;
        n = 0;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk16({15'h0000, cmd_ready}, 16'h0000, "ready in reset");
        rstn = 1'b1;
        @(negedge core_clk);
        chk_st(bank_status, ST_BUSY, "boot busy");
        while (cmd_ready !== 1'b1 && n < 30) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 30) i_master.hangs++;
        chk16(16'(n), 16'h0008, "boot length");
        chk_st(bank_status, ST_READY, "boot end");
        end_test("startup");
    endtask : t_startup

    task automatic t_defaults;
        req_chk(OP_RESTORE, BANK_DEFAULTS, CL_FACTORY, ST_SUCCESS);
        chk16(16'(busy), 16'h0008, "busy length");
        for (int i = 0; i < ITEMS; i++) begin
            rd_chk(i, (i == 2) ? 16'h0100 : 16'h0000, "default item");
        end
        chk16({15'h0000, cal_under_range}, 16'h0001, "under range");
        req_chk(OP_IDLE, 0, CL_FACTORY, ST_READY);
        end_test("defaults");
    endtask : t_defaults

    task automatic t_refuse;
        logic [5:0] bad [9];
        bad = '{6'h04, 6'h08, 6'h19, 6'h16, 6'h1A, 6'h3A, 6'h17, 6'h37, 6'h2B};
        i_master.cfg_write(3'h5, 16'h5555);
        for (int k = 0; k < 9; k++) begin
            req_chk(cbm_op_t'(bad[k][3:2]), bad[k][1:0], cbm_class_t'(bad[k][5:4]), ST_FAIL);
            rd_chk(5, 16'h5555, "ram after refusal");
        end
        end_test("refuse");
    endtask : t_refuse

    task automatic t_banks;
        i_master.diag(CL_SERVICE, DIAG_KEY ^ 16'h0001);
        chk16({15'h0000, diag_rights}, 16'h0000, "wrong code");
        i_master.diag(CL_OPERATOR, DIAG_KEY);
        chk16({15'h0000, diag_rights}, 16'h0000, "operator code");
        i_master.diag(CL_SERVICE, DIAG_KEY);
        chk16({15'h0000, diag_rights}, 16'h0001, "service code");
        for (int b = 2; b >= 0; b--) begin
            for (int i = 0; i < ITEMS; i++) begin
                i_master.cfg_write(3'(i), {4'(b + 1), 12'(i)});
            end
            req_chk(OP_UPDATE, b, CL_SERVICE, ST_SUCCESS);
        end
        for (int s = 0; s < 3; s++) begin
            req_chk(OP_RESTORE, s, CL_FACTORY, ST_SUCCESS);
            for (int i = 0; i < ITEMS; i++) begin
                rd_chk(i, exp_item(s, i), "restored item");
            end
        end
        end_test("banks");
    endtask : t_banks

    task automatic t_cal;
        @(negedge core_clk);
        cal_zero_data = 16'h0C0D;
        cal_gain_data = 16'h0C0E;
        cal_done = 1'b1;
        @(negedge core_clk);
        cal_done = 1'b0;
        cal_zero_data = 16'hF3F2;
        cal_gain_data = 16'hF3F1;
        rd_chk(ITEM_CAL_GAIN, 16'h0C0E, "cal gain in ram");
        i_master.cfg_write(3'h5, 16'hBEEF);
        rd_chk(5, 16'hBEEF, "ram write");
        req_chk(OP_RESTORE, BANK_INSTALL, CL_SUPERVISOR, ST_SUCCESS);
        rd_chk(3, 16'h2003, "install bank kept");
        req_chk(OP_RESTORE, BANK_USER, CL_SUPERVISOR, ST_SUCCESS);
        rd_chk(3, 16'h0C0D, "cal zero in user bank");
        rd_chk(4, 16'h0C0E, "cal gain in user bank");
        rd_chk(5, 16'h1005, "bank not written");
        chk16({15'h0000, cal_under_range}, 16'h0000, "in range");
        end_test("calibration");
    endtask : t_cal

    task automatic t_mon;
        @(negedge core_clk);
        for (int k = 0; k < 6; k++) begin
            mon_in[k] = {12'hA50, 4'(k)};
        end
        repeat (2) @(negedge core_clk);
        for (int k = 0; k < 6; k++) begin
            chk16(mon_out[k], {12'hA50, 4'(k)}, "monitor output");
        end
        for (int k = 0; k < 8; k++) begin
            mon_rd_idx = 3'(k);
            @(negedge core_clk);
            chk16(mon_rd_data, (k < 6) ? {12'hA50, 4'(k)} : (k == 6) ? 16'h0002 : 16'h0000, "group");
        end
        end_test("monitor");
    endtask : t_mon

    initial begin
        t_startup();
        t_defaults();
        t_refuse();
        t_banks();
        t_cal();
        t_mon();
        give_verdict();
    end
endmodule : cbm_config_bank_manager_test
`default_nettype wire
